// *** core/drb_pkg.sv ***
// shared constants and types for the read/write burst sequencing link
package drb_pkg;

  // ==========================================================
  // link widths and depths
  localparam int DQ_W      = 16;  // two beats of 8 bits per clock
  localparam int ADDR_W    = 18;
  localparam int SLOTS     = 64;  // schedule depth in clocks
  localparam int COL_W     = 4;
  localparam int BEAT_W    = 2;   // clock index inside a burst
  localparam int MEM_AW    = COL_W + BEAT_W;
  localparam int MEM_WORDS = 64;

  // ==========================================================
  // mode word fields (carried on addr by a mode-set command)
  localparam int MR_BL_LO  = 0;
  localparam int BL_W      = 2;
  localparam int MR_RPRE   = 2;   // 1: two-clock read preamble
  localparam int MR_WPRE   = 3;   // 1: two-clock write preamble
  localparam int MR_CL_LO  = 4;
  localparam int CL_W      = 5;
  localparam int MR_CWL_LO = 9;
  localparam int CWL_W     = 5;
  localparam int MR_AL_LO  = 14;
  localparam int AL_W      = 4;
  localparam logic [ADDR_W-1:0] MR_RESET = 18'h012B0;  // cl 11, cwl 9, al 0, fixed 8

  localparam logic [BL_W-1:0] BL_FIX8 = 2'h0;
  localparam logic [BL_W-1:0] BL_OTF  = 2'h1;
  localparam logic [BL_W-1:0] BL_FIX4 = 2'h2;

  // ==========================================================
  // column command address fields
  localparam int COL_LO  = 0;
  localparam int A12_BIT = 12;

  // ==========================================================
  // burst lengths and command spacing, in clocks
  localparam int BURST8_CK   = 4;
  localparam int BURST4_CK   = 2;
  localparam int CCD_MIN     = 4;
  localparam int CCD_NO_PRE2 = 5;  // spacing barred with two-clock read preamble
  localparam int RD2WR_BL8   = 8;
  localparam int RD2WR_BC4   = 6;
  localparam int WR2RD_EXTRA = 4;
  localparam int WR2WR_MIN   = 4;
  localparam int PRE2_CK     = 2;

  // ==========================================================
  // commands on the link
  typedef enum logic [2:0] {
    CMD_DES, CMD_RD, CMD_WR, CMD_MRS, CMD_ACT, CMD_PRE
  } drb_cmd_t;

  // ==========================================================
  // controller register map (AXI4-Lite byte addresses)
  localparam int AXI_AW = 5;
  localparam logic [AXI_AW-1:0] REG_CFG    = 5'h00;
  localparam logic [AXI_AW-1:0] REG_CMD    = 5'h04;
  localparam logic [AXI_AW-1:0] REG_WDATA  = 5'h08;
  localparam logic [AXI_AW-1:0] REG_STATUS = 5'h0C;
  localparam logic [AXI_AW-1:0] REG_RDATA  = 5'h10;
  localparam int CR_WR     = 0;
  localparam int CR_A12    = 1;
  localparam int CR_COL_LO = 4;
  localparam int ST_BUSY   = 0;
  localparam int ST_FLIGHT = 1;
  localparam int ST_CNT_LO = 8;
  localparam int CNT_W     = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : drb_pkg

// *** core/drb_if.sv ***
// link between the burst controller and the memory device
`timescale 1ns/1ps
`default_nettype none
interface drb_if;
  import drb_pkg::*;

  // command and address, driven by the controller
  drb_cmd_t            cmd;
  logic [ADDR_W-1:0]   addr;
  // controller side of the data and strobe pins
  logic [DQ_W-1:0]     c_dq;
  logic                c_dq_oe_n;
  logic                c_dqs;
  logic                c_dqs_oe_n;
  // device side of the data and strobe pins
  logic [DQ_W-1:0]     d_dq;
  logic                d_dq_oe_n;
  logic                d_dqs;
  logic                d_dqs_oe_n;
  // resolved pin levels, low when nobody drives
  logic [DQ_W-1:0]     dq;
  logic                dqs;

  assign dq  = !c_dq_oe_n ? c_dq : (!d_dq_oe_n ? d_dq : '0);
  assign dqs = !c_dqs_oe_n ? c_dqs : (!d_dqs_oe_n ? d_dqs : 1'b0);

  modport ctrl (output cmd, addr, c_dq, c_dq_oe_n, c_dqs, c_dqs_oe_n, input dq, dqs);
  modport dev  (input cmd, addr, dq, dqs, output d_dq, d_dq_oe_n, d_dqs, d_dqs_oe_n);
endinterface : drb_if
`default_nettype wire

// *** core/drb_dev.sv ***
// memory device end: mode register, read and write burst scheduling
`timescale 1ns/1ps
`default_nettype none
module drb_dev
  import drb_pkg::*;
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // link to the controller
  drb_if.dev               link,
  // observation of the live mode and burst activity
  output logic [BL_W-1:0]  mode_bl,
  output logic             mode_rpre2,
  output logic             mode_wpre2,
  output logic             burst_busy
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [ADDR_W-1:0]                 mr;
    logic [SLOTS-1:0]                  rv;
    logic [SLOTS-1:0][MEM_AW-1:0]      ra;
    logic [SLOTS-1:0]                  wv;
    logic [SLOTS-1:0][MEM_AW-1:0]      wa;
    logic [MEM_WORDS-1:0][DQ_W-1:0]    mem;
    logic [DQ_W-1:0]                   dq;
    logic                              dq_oe_n;
    logic                              dqs;
    logic                              dqs_oe_n;
    logic                              busy;
  } drb_dev_st_t;

  localparam drb_dev_st_t ST_RST = '{
    mr:       MR_RESET,
    dq_oe_n:  1'b1,
    dqs_oe_n: 1'b1,
    default:  '0
  };

  drb_dev_st_t s;
  drb_dev_st_t next_s;

  // ==========================================================
  // next state
  always_comb begin
    int                rl;
    int                wl;
    int                idx;
    int                nclk;
    logic              len8;
    logic [BL_W-1:0]   bl;
    logic              drive;
    rl     = 0;
    wl     = 0;
    idx    = 0;
    nclk   = 0;
    len8   = 1'b0;
    bl     = s.mr[MR_BL_LO +: BL_W];
    drive  = 1'b0;
    next_s = s;

    // latencies from the live mode word
    rl = int'(s.mr[MR_CL_LO +: CL_W]) + int'(s.mr[MR_AL_LO +: AL_W]);
    // the controller has already raised cwl for a long write preamble
    wl = int'(s.mr[MR_CWL_LO +: CWL_W]) + int'(s.mr[MR_AL_LO +: AL_W]);

    // one clock of schedule passes
    next_s.rv = {1'b0, s.rv[SLOTS-1:1]};
    next_s.ra = {{MEM_AW{1'b0}}, s.ra[SLOTS-1:1]};
    next_s.wv = {1'b0, s.wv[SLOTS-1:1]};
    next_s.wa = {{MEM_AW{1'b0}}, s.wa[SLOTS-1:1]};

    // write beats land in the array on their scheduled clock
    if (s.wv[0]) begin
      next_s.mem[s.wa[0]] = link.dq;
    end

    // burst length of this command
    unique case (bl)
      BL_FIX8: len8 = 1'b1;
      BL_FIX4: len8 = 1'b0;
      BL_OTF:  len8 = link.addr[A12_BIT];
      default: len8 = 1'b1;                  // reserved code runs as eight
    endcase
    nclk = len8 ? BURST8_CK : BURST4_CK;

    // command decode, every clock, whatever came before
    unique case (link.cmd)
      CMD_RD: begin
        // each read books its own clocks, so mixed lengths just queue
        for (int k = 0; k < BURST8_CK; k++) begin
          idx = rl - 1 + k;
          if (k < nclk && idx >= 0 && idx < SLOTS) begin
            next_s.rv[idx] = 1'b1;
            next_s.ra[idx] = {link.addr[COL_LO +: COL_W], BEAT_W'(k)};
          end
        end
      end
      CMD_WR: begin
        for (int k = 0; k < BURST8_CK; k++) begin
          idx = wl - 1 + k;
          if (k < nclk && idx >= 0 && idx < SLOTS) begin
            next_s.wv[idx] = 1'b1;
            next_s.wa[idx] = {link.addr[COL_LO +: COL_W], BEAT_W'(k)};
          end
        end
      end
      CMD_MRS: begin
        next_s.mr = link.addr;
      end
      CMD_DES, CMD_ACT, CMD_PRE: begin
        // no effect on bursts already booked
        next_s.mr = s.mr;
      end
      default: begin
        // illegal code is treated as a deselect
        next_s.mr = s.mr;
      end
    endcase

    // read drivers: data on booked clocks, strobe from the preamble on
    drive = next_s.rv[0] | next_s.rv[1] | (s.mr[MR_RPRE] & next_s.rv[PRE2_CK]);
    next_s.dq       = next_s.rv[0] ? next_s.mem[next_s.ra[0]] : '0;
    next_s.dq_oe_n  = ~next_s.rv[0];
    // strobe low in the preamble, high on data; adjacent bursts never drop it
    next_s.dqs      = next_s.rv[0];
    next_s.dqs_oe_n = ~drive;
    next_s.busy     = (|next_s.rv) | (|next_s.wv);
  end

  // ==========================================================
  // registers, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state
  assign link.d_dq       = s.dq;
  assign link.d_dq_oe_n  = s.dq_oe_n;
  assign link.d_dqs      = s.dqs;
  assign link.d_dqs_oe_n = s.dqs_oe_n;
  assign mode_bl         = s.mr[MR_BL_LO +: BL_W];
  assign mode_rpre2      = s.mr[MR_RPRE];
  assign mode_wpre2      = s.mr[MR_WPRE];
  assign burst_busy      = s.busy;

endmodule : drb_dev
`default_nettype wire

// *** core/drb_ctrl.sv ***
// controller end: AXI4-Lite registers, command spacing, write data and read capture
//
// Behaviour
// - mode 00: every burst is eight beats
// - mode 10: every read is chopped to four
// - mode 01: a12 picks each read's length
// - mode 01: a12 picks each write's length
// - two-clock read preamble: no five-clock read spacing
// - two-clock write preamble: raise write latency by one
// - write latency is cwl plus al
// - other commands accepted between reads and writes
// - read data starts cl plus al after read
`timescale 1ns/1ps
`default_nettype none
module drb_ctrl
  import drb_pkg::*;
(
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // link to the device
  drb_if.ctrl                    link,
  // AXI4-Lite write channels
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]             cfg;
    logic [DQ_W-1:0]         wd;
    logic [ADDR_W-1:0]       mr;
    logic                    mrs_pend;
    logic                    op_pend;
    logic                    op_wr;
    logic                    op_a12;
    logic [COL_W-1:0]        op_col;
    logic [5:0]              since_rd;
    logic [5:0]              since_wr;
    logic                    last_rd8;
    logic [SLOTS-1:0]        rs;
    logic [SLOTS-1:0]        ws;
    logic [SLOTS-1:0][1:0]   wb;
    logic [DQ_W-1:0]         rd_last;
    logic [CNT_W-1:0]        rd_cnt;
    drb_cmd_t                cmd;
    logic [ADDR_W-1:0]       addr;
    logic [DQ_W-1:0]         dq;
    logic                    dq_oe_n;
    logic                    dqs;
    logic                    dqs_oe_n;
    logic                    aw_have;
    logic [AXI_AW-1:0]       aw_a;
    logic                    w_have;
    logic [31:0]             w_d;
    logic [3:0]              w_s;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } drb_ctrl_st_t;

  localparam drb_ctrl_st_t ST_RST = '{
    cfg: {14'h0000, MR_RESET}, mr: MR_RESET, cmd: CMD_DES,
    since_rd: 6'h3F, since_wr: 6'h3F, dq_oe_n: 1'b1, dqs_oe_n: 1'b1,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0
  };

  drb_ctrl_st_t s;
  drb_ctrl_st_t next_s;

  // ==========================================================
  // next state
  always_comb begin
    int                rl;
    int                wl;
    int                nclk;
    logic              len8;
    logic [31:0]       v;
    logic [ADDR_W-1:0] mw;
    rl     = int'(s.mr[MR_CL_LO +: CL_W]) + int'(s.mr[MR_AL_LO +: AL_W]);
    wl     = int'(s.mr[MR_CWL_LO +: CWL_W]) + int'(s.mr[MR_AL_LO +: AL_W]);
    nclk   = 0;
    len8   = 1'b0;
    v      = 32'h0000_0000;
    mw     = s.cfg[ADDR_W-1:0];
    next_s = s;

    // bus channels: take address and data in either order
    if (awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_a    = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.w_d    = wdata;
      next_s.w_s    = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // a write waits while an earlier order is still unsent
    if (s.aw_have && s.w_have && !s.bvalid && !s.op_pend && !s.mrs_pend) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      v = (s.aw_a == REG_CFG) ? s.cfg : {16'h0000, s.wd};
      for (int b = 0; b < 4; b++) begin
        if (s.w_s[b]) v[8*b +: 8] = s.w_d[8*b +: 8];
      end
      unique case (s.aw_a)
        REG_CFG: begin
          next_s.cfg      = v;
          next_s.mrs_pend = 1'b1;
        end
        REG_CMD: begin
          next_s.op_pend = 1'b1;
          next_s.op_wr   = s.w_d[CR_WR];
          next_s.op_a12  = s.w_d[CR_A12];
          next_s.op_col  = s.w_d[CR_COL_LO +: COL_W];
        end
        REG_WDATA: next_s.wd = v[DQ_W-1:0];
        default:   next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      unique case (araddr)
        REG_CFG:    next_s.rdata = s.cfg;
        REG_WDATA:  next_s.rdata = {16'h0000, s.wd};
        REG_STATUS: next_s.rdata = {16'h0000, s.rd_cnt, 6'h00, |s.rs | |s.ws,
                                    s.op_pend | s.mrs_pend};
        REG_RDATA:  next_s.rdata = {16'h0000, s.rd_last};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // schedule advances, spacing counters saturate
    next_s.rs = {1'b0, s.rs[SLOTS-1:1]};
    next_s.ws = {1'b0, s.ws[SLOTS-1:1]};
    next_s.wb = {2'h0, s.wb[SLOTS-1:1]};
    if (s.since_rd != 6'h3F) next_s.since_rd = s.since_rd + 6'h01;
    if (s.since_wr != 6'h3F) next_s.since_wr = s.since_wr + 6'h01;
    next_s.cmd  = CMD_DES;
    next_s.addr = '0;

    // read beats are caught rl clocks after the command
    if (s.rs[0]) begin
      next_s.rd_last = link.dq;
      next_s.rd_cnt  = s.rd_cnt + 8'h01;
    end

    // length of the pending order under the live mode
    unique case (s.mr[MR_BL_LO +: BL_W])
      BL_FIX8: len8 = 1'b1;
      BL_FIX4: len8 = 1'b0;
      BL_OTF:  len8 = s.op_a12;
      default: len8 = 1'b1;
    endcase
    nclk = len8 ? BURST8_CK : BURST4_CK;

    // mode change only with the link quiet
    if (s.mrs_pend && s.rs == '0 && s.ws == '0 && int'(s.since_wr) > wl + BURST8_CK) begin
      // long write preamble costs one more clock of write latency
      mw[MR_CWL_LO +: CWL_W] = s.cfg[MR_CWL_LO +: CWL_W] + CWL_W'(s.cfg[MR_WPRE]);
      next_s.cmd      = CMD_MRS;
      next_s.addr     = mw;
      next_s.mr       = mw;
      next_s.mrs_pend = 1'b0;
    end else if (s.op_pend && !s.op_wr && int'(s.since_rd) >= CCD_MIN &&
                 !(s.mr[MR_RPRE] && int'(s.since_rd) == CCD_NO_PRE2) &&
                 int'(s.since_wr) >= wl + BURST8_CK + WR2RD_EXTRA) begin
      next_s.cmd             = CMD_RD;
      next_s.addr[A12_BIT]   = s.op_a12;
      next_s.addr[COL_LO +: COL_W] = s.op_col;
      next_s.op_pend         = 1'b0;
      next_s.since_rd        = 6'h01;
      next_s.last_rd8        = len8;
      for (int k = 0; k < BURST8_CK; k++) begin
        if (k < nclk && rl + k < SLOTS) next_s.rs[rl + k] = 1'b1;
      end
    end else if (s.op_pend && s.op_wr && int'(s.since_wr) >= WR2WR_MIN &&
                 int'(s.since_rd) >= (s.last_rd8 ? RD2WR_BL8 : RD2WR_BC4)) begin
      next_s.cmd             = CMD_WR;
      next_s.addr[A12_BIT]   = s.op_a12;
      next_s.addr[COL_LO +: COL_W] = s.op_col;
      next_s.op_pend         = 1'b0;
      next_s.since_wr        = 6'h01;
      for (int k = 0; k < BURST8_CK; k++) begin
        if (k < nclk && wl + k < SLOTS) begin
          next_s.ws[wl + k] = 1'b1;
          next_s.wb[wl + k] = 2'(k);
        end
      end
    end

    // write drivers; beat index folded into data so beats differ
    next_s.dq       = next_s.ws[0] ? (s.wd ^ DQ_W'(next_s.wb[0])) : '0;
    next_s.dq_oe_n  = ~next_s.ws[0];
    next_s.dqs      = next_s.ws[0];
    next_s.dqs_oe_n = ~(next_s.ws[0] | next_s.ws[1] | (s.mr[MR_WPRE] & next_s.ws[PRE2_CK]));
    next_s.awready  = ~next_s.aw_have;
    next_s.wready   = ~next_s.w_have;
    next_s.arready  = ~next_s.rvalid;
  end

  // ==========================================================
  // registers, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign link.cmd        = s.cmd;
  assign link.addr       = s.addr;
  assign link.c_dq       = s.dq;
  assign link.c_dq_oe_n  = s.dq_oe_n;
  assign link.c_dqs      = s.dqs;
  assign link.c_dqs_oe_n = s.dqs_oe_n;
  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rdata           = s.rdata;
  assign rresp           = s.rresp;

endmodule : drb_ctrl
`default_nettype wire

// *** test/drb_checker.sv ***
// link checker for the burst controller and device pair
`timescale 1ns/1ps
`default_nettype none
module drb_checker
  import drb_pkg::*;
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // link
  input wire drb_cmd_t          cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              c_dq_oe_n,
  input wire logic              d_dq_oe_n,
  input wire logic              d_dqs_oe_n
);
  // ==========================================
  // mode word seen on the link, read history
  logic [ADDR_W-1:0] mw;
  logic [10:0]       rdp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mw  <= MR_RESET;
      rdp <= '0;
    end else begin
      mw  <= (cmd == CMD_MRS) ? addr : mw;
      rdp <= {rdp[9:0], cmd == CMD_RD};
    end
  end
  // delays must be fixed, so rd and wr only count at latency 11 with additive 0; a_gap and a_src are not gated
  wire logic [BL_W-1:0]  bl  = mw[MR_BL_LO +: BL_W];
  wire logic [CWL_W-1:0] cwl = mw[MR_CWL_LO +: CWL_W];
  wire logic lat11 = mw[MR_CL_LO +: CL_W] == 5'h0B && mw[MR_AL_LO +: AL_W] == 4'h0;
  wire logic a12 = addr[A12_BIT];
  wire logic rd  = cmd == CMD_RD && lat11;
  wire logic wr  = cmd == CMD_WR && lat11;
  wire logic rd8 = rd && (bl == BL_FIX8 || (bl == BL_OTF && a12));
  // ==========================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_d8; (!d_dq_oe_n) [*4]; endsequence
  sequence s_d4; (!d_dq_oe_n) [*2] ##1 d_dq_oe_n; endsequence
  property p_lat; rd |-> ##10 !d_dqs_oe_n ##1 !d_dq_oe_n; endproperty
  a_lat: assert property (p_lat) else $error("read data misplaced");
  property p_f8; rd && bl == BL_FIX8 |-> ##11 s_d8; endproperty
  a_f8: assert property (p_f8) else $error("fixed burst not eight");
  property p_f4; rd && bl == BL_FIX4 |-> ##11 s_d4; endproperty
  a_f4: assert property (p_f4) else $error("fixed chop not four");
  property p_o8; rd && bl == BL_OTF && a12 |-> ##11 s_d8; endproperty
  a_o8: assert property (p_o8) else $error("a12 high not eight");
  property p_o4; rd && bl == BL_OTF && !a12 |-> ##11 s_d4; endproperty
  a_o4: assert property (p_o4) else $error("a12 low not four");
  property p_seam; rd8 ##4 rd8 |-> ##7 (!d_dq_oe_n) [*8]; endproperty
  a_seam: assert property (p_seam) else $error("gap between bursts");
  property p_src; $fell(d_dq_oe_n) |-> rdp[10]; endproperty
  a_src: assert property (p_src) else $error("data without read");
  property p_wl10; wr && cwl == 5'h0A |-> ##10 !c_dq_oe_n; endproperty
  a_wl10: assert property (p_wl10) else $error("write data not at ten");
  property p_w4;
    wr && bl == BL_OTF && !a12 && cwl == 5'h09 |-> ##9 (!c_dq_oe_n) [*2] ##1 c_dq_oe_n;
  endproperty
  a_w4: assert property (p_w4) else $error("short write wrong");
  property p_gap; cmd == CMD_RD && mw[MR_RPRE] |-> ##5 cmd != CMD_RD; endproperty
  a_gap: assert property (p_gap) else $error("reads five apart");
endmodule : drb_checker
`default_nettype wire

// *** test/tb_ddr4_read_burst_sequencing.sv ***
// bench: both ends joined on the link, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_ddr4_read_burst_sequencing import drb_pkg::*;;
  // ==========================================
  // signals
  logic              aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, busy, rp2, wp2;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, mbl;
  int                n_mismatch, cmp_count;
  int                dclk = 0;
  // ==========================================
  // both ends and the checker
  drb_if drb_if_i ();
  drb_dev drb_dev_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(drb_if_i),
    .mode_bl(mbl), .mode_rpre2(rp2), .mode_wpre2(wp2), .burst_busy(busy));
  drb_ctrl drb_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(drb_if_i),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  drb_checker drb_checker_i (.aclk(aclk), .aresetn(aresetn), .cmd(drb_if_i.cmd),
    .addr(drb_if_i.addr), .c_dq_oe_n(drb_if_i.c_dq_oe_n),
    .d_dq_oe_n(drb_if_i.d_dq_oe_n), .d_dqs_oe_n(drb_if_i.d_dqs_oe_n));
  // device data clocks seen on the wire
  always @(posedge aclk) begin
    if (drb_if_i.d_dq_oe_n === 1'b0) begin
      dclk <= dclk + 1;
    end
  end
  // ==========================================
  // bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // write address and data offered together, bready held until answer
  task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask : axw
  task automatic axr(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axr
  // polls until no order is pending and nothing is in flight
  task automatic idle();
    logic [31:0] s;
    logic [1:0]  r;
    do begin
      axr(REG_STATUS, s, r);
    end while (s[1:0] !== 2'b00 || busy !== 1'b0);
  endtask : idle
  task automatic op(input logic w, input logic a, input logic [3:0] c);
    axw(REG_CMD, {24'h0, c, 2'b00, a, w}, RESP_OKAY);
  endtask : op
  task automatic wrd(input logic a, input logic [3:0] c, input logic [15:0] d);
    axw(REG_WDATA, {16'h0, d}, RESP_OKAY);
    op(1'b1, a, c);
  endtask : wrd
  task automatic cfg(input logic [1:0] b, input logic p, input logic w);
    logic [31:0] d;
    logic [1:0]  r;
    idle();
    axw(REG_CFG, {28'h000012B, w, p, b}, RESP_OKAY);
    axr(REG_CFG, d, r);
    chk(d, {28'h000012B, w, p, b});
    idle();
    chk({28'h0, wp2, rp2, mbl}, {28'h0, w, p, b});
  endtask : cfg
  // one read: clock count in status, on the wire, and last data clock
  task automatic rdc(input logic a, input logic [3:0] c, input logic [7:0] n,
                     input logic [31:0] e);
    logic [31:0] s0, s1, d;
    logic [1:0]  r;
    int          k;
    idle();
    axr(REG_STATUS, s0, r);
    k = dclk;
    op(1'b0, a, c);
    idle();
    axr(REG_STATUS, s1, r);
    chk({24'h0, s1[15:8] - s0[15:8]}, {24'h0, n});
    chk(dclk - k, {24'h0, n});
    axr(REG_RDATA, d, r);
    chk(d, e);
  endtask : rdc
  // two reads ordered back to back, the second g clocks later
  task automatic rd2(input logic a, input logic b, input logic [7:0] n, input int g = 0);
    int k;
    idle();
    k = dclk;
    op(1'b0, a, 4'h1);
    repeat (g) @(posedge aclk);
    op(1'b0, b, 4'h2);
    idle();
    chk(dclk - k, {24'h0, n});
  endtask : rd2
  // ==========================================
  // scenarios
  task automatic s_reset();
    logic [31:0] d;
    logic [1:0]  r;
    axr(REG_CFG, d, r);
    chk(d, 32'h000012B0);
    axr(5'h14, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    axw(5'h14, 32'h0000FFFF, RESP_SLVERR);
  endtask : s_reset
  task automatic s_fixed();
    wrd(1'b0, 4'h3, 16'hA5C0);
    rdc(1'b0, 4'h3, 8'h04, 32'h0000A5C3);
    rd2(1'b0, 1'b0, 8'h08);
    cfg(BL_FIX4, 1'b0, 1'b0);
    wrd(1'b1, 4'h3, 16'h1230);
    rdc(1'b1, 4'h3, 8'h02, 32'h00001231);
    rd2(1'b1, 1'b1, 8'h04);
  endtask : s_fixed
  task automatic s_otf();
    cfg(BL_OTF, 1'b0, 1'b0);
    wrd(1'b1, 4'h5, 16'h7700);
    idle(); // beats of the first write use the live WDATA
    wrd(1'b0, 4'h5, 16'h6600);
    rdc(1'b1, 4'h5, 8'h04, 32'h00007703);
    rdc(1'b0, 4'h5, 8'h02, 32'h00006601);
    rd2(1'b0, 1'b1, 8'h06);
  endtask : s_otf
  task automatic s_pre2();
    cfg(BL_FIX8, 1'b1, 1'b1);
    op(1'b0, 1'b1, 4'h7);
    wrd(1'b1, 4'h7, 16'h4B40);
    rdc(1'b1, 4'h7, 8'h04, 32'h00004B43);
    rd2(1'b1, 1'b1, 8'h08);
    rd2(1'b1, 1'b1, 8'h08, 1);
  endtask : s_pre2
  // ce low: a read request waits, then completes once ce returns
  task automatic s_hold();
    idle();
    @(posedge aclk);
    ce      <= 1'b0;
    araddr  <= REG_CFG;
    arvalid <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, rvalid}, 32'h0);
    ce     <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, 32'h000012BC);
  endtask : s_hold
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ==========================================
  // clock, sequence, watchdog
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_fixed();
    s_otf();
    s_pre2();
    s_hold();
    complete_run();
  end
  // generous bound: a few hundred cycles are expected
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_ddr4_read_burst_sequencing
`default_nettype wire
